// File: bench/ecso_chk_sva.sv
// Concurrent checks on the link between the two checksum offload ends
`timescale 1ns/1ns
module ecso_chk
(
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        rx_en,
	input wire logic        rx_in_valid,
	input wire logic [7:0]  rx_in_data,
	input wire logic        rx_in_last,
	input wire logic        rx_out_valid,
	input wire logic [7:0]  rx_out_data,
	input wire logic        rx_out_last,
	input wire logic        rx_len_valid,
	input wire logic [13:0] rx_len,
	input wire logic        tx_out_valid,
	input wire logic [7:0]  tx_out_data,
	input wire logic        tx_out_ready
);
	// Bytes of the receive frame so far, so lengths can be tied to real traffic
	logic [13:0] cnt_reg;
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			cnt_reg <= 14'h0000;
		else if (rx_in_valid)
			cnt_reg <= rx_in_last ? 14'h0000 : cnt_reg + 14'h0001;

	// ****************************************************************
	// Stream rules
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_rx_byte_fwd: assert property (
		rx_in_valid |=> rx_out_valid && rx_out_data == $past(rx_in_data))
		else $error("receive byte not forwarded");
	a_rx_plain_end: assert property (
		rx_in_valid && rx_in_last && !rx_en
		|=> rx_out_last && rx_len_valid && rx_len == $past(cnt_reg) + 14'h0001)
		else $error("plain frame end wrong");
	a_rx_sum_slots: assert property (
		rx_in_valid && rx_in_last && rx_en |=> !rx_out_last ##1 !rx_out_valid
		##1 rx_out_valid && !rx_out_last ##1 rx_out_valid && rx_out_last)
		else $error("sum bytes misplaced");
	a_len_plus_two: assert property (
		rx_in_valid && rx_in_last && rx_en
		|-> ##4 rx_len_valid && rx_len == $past(cnt_reg, 4) + 14'h0003)
		else $error("length not grown by two");
	a_len_at_end: assert property (
		rx_len_valid |-> rx_out_valid && rx_out_last)
		else $error("length away from frame end");
	a_end_has_len: assert property (
		rx_out_valid && rx_out_last |-> rx_len_valid)
		else $error("frame end without length");
	a_rx_no_extra: assert property (
		rx_out_valid && !rx_en |-> $past(rx_in_valid))
		else $error("extra byte while disabled");
	a_tx_hold: assert property (
		tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_data))
		else $error("transmit byte dropped in stall");
	c_sum_frame: cover property (rx_in_valid && rx_in_last && rx_en);
	c_plain_end: cover property (rx_in_valid && rx_in_last && !rx_en);
	c_tx_stall: cover property (tx_out_valid && !tx_out_ready);
endmodule

// File: bench/test_ethernet_checksum_offload.sv
// Self-checking bench: both offload ends joined, driven over APB and MAC ports
`timescale 1ns/1ns
module test_ethernet_checksum_offload
	import ecso_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        mrx_v = 1'b0;
	logic        mrx_l = 1'b0;
	logic [7:0]  mrx_d = 8'h00;
	logic        mtx_rdy = 1'b0;
	logic [1:0]  tick = 2'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, fifo_v, fifo_l, st_v, mtx_v, mtx_l, sum_v;
	logic [7:0]  fifo_d, mtx_d;
	logic [13:0] st_len, stat_len;
	logic [15:0] rx_sum;
	logic [7:0]  fr [0:63];
	logic [7:0]  rxq [$];
	logic [7:0]  txq [$];
	int          mismatches = 0;
	int          n_compared = 0;
	int          stat_n = 0, sum_n = 0;
	int          tx_end = 0;

	ecso_if i_ecso_if ();
	ecso_engine i_ecso_engine (.CLK(clk), .RST_N(rst_n), .LINK(i_ecso_if.engine),
		.RX_SUM(rx_sum), .RX_SUM_VALID(sum_v));
	ecso_mac i_ecso_mac (.CLK(clk), .RST_N(rst_n), .LINK(i_ecso_if.mac), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .MAC_RX_VALID(mrx_v), .MAC_RX_DATA(mrx_d),
		.MAC_RX_LAST(mrx_l), .RX_FIFO_VALID(fifo_v), .RX_FIFO_DATA(fifo_d),
		.RX_FIFO_LAST(fifo_l), .RX_STATUS_VALID(st_v), .RX_STATUS_LEN(st_len),
		.MAC_TX_VALID(mtx_v), .MAC_TX_DATA(mtx_d), .MAC_TX_LAST(mtx_l), .MAC_TX_READY(mtx_rdy));
	ecso_chk i_ecso_chk (.CLK(clk), .RST_N(rst_n), .rx_en(i_ecso_if.rx_en),
		.rx_in_valid(i_ecso_if.rx_in_valid), .rx_in_data(i_ecso_if.rx_in_data),
		.rx_in_last(i_ecso_if.rx_in_last), .rx_out_valid(i_ecso_if.rx_out_valid),
		.rx_out_data(i_ecso_if.rx_out_data), .rx_out_last(i_ecso_if.rx_out_last),
		.rx_len_valid(i_ecso_if.rx_len_valid), .rx_len(i_ecso_if.rx_len),
		.tx_out_valid(i_ecso_if.tx_out_valid), .tx_out_data(i_ecso_if.tx_out_data),
		.tx_out_ready(i_ecso_if.tx_out_ready));

	// 100 MHz clock
	always #5 clk = ~clk;

	// Collect both outputs; the far MAC stalls every fourth cycle to test holding
	always @(posedge clk)
	begin
		if (fifo_v === 1'b1)
			rxq.push_back(fifo_d);
		if (st_v === 1'b1)
		begin
			stat_len = st_len;
			stat_n++;
		end
		if (sum_v === 1'b1)
			sum_n++;
		if (mtx_v === 1'b1 && mtx_rdy === 1'b1)
			txq.push_back(mtx_d);
		if (mtx_v === 1'b1 && mtx_rdy === 1'b1 && mtx_l === 1'b1)
			tx_end = txq.size();
		tick <= tick + 2'h1;
		mtx_rdy <= (tick != 2'h3);
	end

	// ****************************************************************
	// Access tasks and reference sum
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; read data is compared only when no error is expected
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
		if (!w && !ee)
			chk("prdata", d, prdata);
	endtask

	// Stop the datapath before touching the offload bits, then restart it
	task automatic cfg(input logic [31:0] off, input logic [31:0] run);
		apb(1'b1, REG_MAC_CTRL, 32'h0, 1'b0);
		apb(1'b1, REG_OFF_CTRL, off, 1'b0);
		apb(1'b1, REG_MAC_CTRL, run, 1'b0);
	endtask

	task automatic put(input int i, input logic [15:0] v);
		fr[i] = v[15:8];
		fr[i + 1] = v[7:0];
	endtask

	// Later byte is the high half; an odd tail is padded with zero
	function automatic logic [15:0] csum(input int s, input int e);
		logic [16:0] a;
		logic [7:0]  hi;
		a = 17'h0;
		for (int i = s; i < e; i += 2)
		begin
			hi = (i + 1 < e) ? fr[i + 1] : 8'h00;
			a = a[15:0] + {hi, fr[i]};
			a = a[15:0] + a[16];
		end
		return a[15:0];
	endfunction

	task automatic rx_frame(input int n, input int s, input logic en);
		logic [15:0] sum;
		int          k;
		sum = csum(s, n - 4);
		rxq.delete();
		stat_n = 0;
		sum_n = 0;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			mrx_v <= 1'b1;
			mrx_d <= fr[i];
			mrx_l <= (i == n - 1);
		end
		@(posedge clk);
		mrx_v <= 1'b0;
		mrx_l <= 1'b0;
		for (k = 0; k < 40 && stat_n == 0; k++)
			@(posedge clk);
		chk("rx count", 32'(n + (en ? 2 : 0)), 32'(rxq.size()));
		for (k = 0; k < n && k < rxq.size(); k++)
			chk("rx byte", {24'h0, fr[k]}, {24'h0, rxq[k]});
		chk("rx status length", 32'(n + (en ? 2 : 0)), {18'h0, stat_len});
		chk("rx sum valid", 32'(en), 32'(sum_n));
		if (en)
		begin
			chk("rx sum bytes", {16'h0, sum}, {16'h0, rxq[n + 1], rxq[n]});
			chk("rx sum port", {16'h0, sum}, {16'h0, rx_sum});
		end
	endtask

	// A 24 byte packet; sum from 14 to the end, inserted at 18
	task automatic tx_pkt(input logic req, input logic fs);
		logic [15:0] s;
		logic        ins;
		int          k;
		ins = req & fs;
		s = ~csum(14, 24);
		txq.delete();
		tx_end = 0;
		apb(1'b1, REG_TX_DATA, 32'(fs) << CMDA_FS_BIT, 1'b0);
		apb(1'b1, REG_TX_DATA, (32'(req) << CMDB_REQ_BIT) | (ins ? 32'd28 : 32'd24), 1'b0);
		if (ins)
			apb(1'b1, REG_TX_DATA, (32'd18 << PRE_LOC_LSB) | (32'd14 << PRE_START_LSB), 1'b0);
		for (k = 0; k < 24; k += 4)
			apb(1'b1, REG_TX_DATA, {fr[k + 3], fr[k + 2], fr[k + 1], fr[k]}, 1'b0);
		for (k = 0; k < 300 && txq.size() < 24; k++)
			@(posedge clk);
		chk("tx count", 32'd24, 32'(txq.size()));
		chk("tx end", 32'd24, 32'(tx_end));
		for (k = 0; k < 24; k++)
			chk("tx byte", {24'h0, (ins && k == 18) ? s[7:0] : (ins && k == 19) ? s[15:8]
				: fr[k]}, {24'h0, txq[k]});
	endtask

	task automatic report_and_stop();
		if (mismatches == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial
	begin
		for (int i = 0; i < 64; i++)
			fr[i] = 8'(i * 37 + 5);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, REG_VLAN, 32'h8100, 1'b0);
		apb(1'b0, 12'h018, 32'h0, 1'b1);
		apb(1'b1, REG_STATUS, 32'h0, 1'b1);
		apb(1'b1, REG_MAC_CTRL, 32'h4, 1'b0);
		rx_frame(41, 14, 1'b0);
		apb(1'b1, REG_OFF_CTRL, 32'h1, 1'b1);
		cfg(32'h1, 32'h4);
		apb(1'b1, REG_MAC_CTRL, 32'h104, 1'b1);
		rx_frame(41, 14, 1'b1);
		cfg(32'h3, 32'h4);
		put(12, 16'h8100);
		put(16, 16'h8100);
		put(20, 16'h0040);
		rx_frame(41, 30, 1'b1);
		apb(1'b1, REG_VLAN, 32'h9100, 1'b0);
		put(12, 16'h9100);
		put(16, 16'h9100);
		put(20, 16'h9100);
		rx_frame(41, 22, 1'b1);
		apb(1'b0, REG_RX_LEN, 32'd43, 1'b0);
		apb(1'b0, REG_STATUS, 32'h0004_0000, 1'b0);
		cfg(32'h10000, 32'h8);
		tx_pkt(1'b1, 1'b1);
		tx_pkt(1'b0, 1'b1);
		tx_pkt(1'b1, 1'b0);
		report_and_stop();
	end
endmodule

// File: include/ecso_if.sv
// Link between the offload engines and the MAC side controller
`timescale 1ns/1ns
interface ecso_if;
	logic        rx_en;
	logic        rx_mode;
	logic        tx_en;
	logic [15:0] vlan_tpid;
	logic        rx_in_valid;
	logic [7:0]  rx_in_data;
	logic        rx_in_last;
	logic        rx_out_valid;
	logic [7:0]  rx_out_data;
	logic        rx_out_last;
	logic        rx_len_valid;
	logic [13:0] rx_len;
	logic        rx_busy;
	logic        tx_in_valid;
	logic [31:0] tx_in_data;
	logic        tx_in_ready;
	logic        tx_out_valid;
	logic [7:0]  tx_out_data;
	logic        tx_out_last;
	logic        tx_out_ready;
	logic        tx_busy;

	modport engine (
		input  rx_en, rx_mode, tx_en, vlan_tpid, rx_in_valid, rx_in_data, rx_in_last,
		input  tx_in_valid, tx_in_data, tx_out_ready,
		output rx_out_valid, rx_out_data, rx_out_last, rx_len_valid, rx_len, rx_busy,
		output tx_in_ready, tx_out_valid, tx_out_data, tx_out_last, tx_busy
	);

	modport mac (
		output rx_en, rx_mode, tx_en, vlan_tpid, rx_in_valid, rx_in_data, rx_in_last,
		output tx_in_valid, tx_in_data, tx_out_ready,
		input  rx_out_valid, rx_out_data, rx_out_last, rx_len_valid, rx_len, rx_busy,
		input  tx_in_ready, tx_out_valid, tx_out_data, tx_out_last, tx_busy
	);
endinterface

// File: include/ecso_pkg.sv
// Shared constants, register map and state codes of the checksum offload datapath
package ecso_pkg;

	// ****************************************************************
	// Receive frame layout
	// ****************************************************************
	localparam logic [13:0] RX_HDR_LEN    = 14'h000e;
	localparam logic [13:0] RX_TYPE_POS   = 14'h000c;
	localparam logic [13:0] RX_FCS_LEN    = 14'h0004;
	localparam logic [13:0] RX_TAG_LEN    = 14'h0004;
	localparam logic [13:0] RX_TYPE_LEN   = 14'h0002;
	localparam logic [13:0] RX_SNAP_LEN   = 14'h0008;
	localparam logic [13:0] RX_APPEND_LEN = 14'h0002;
	localparam logic [13:0] RX_START_NONE = 14'h3fff;
	localparam logic [15:0] RX_TYPE_MIN   = 16'h0600;
	localparam logic [1:0]  RX_MAX_VLAN   = 2'h2;
	localparam logic [15:0] VLAN_TPID_RST = 16'h8100;

	// ****************************************************************
	// Transmit command and preamble fields
	// ****************************************************************
	localparam int CMDA_FS_BIT   = 13;
	localparam int CMDB_REQ_BIT  = 14;
	localparam int PRE_START_LSB = 0;
	localparam int PRE_LOC_LSB   = 16;
	localparam int PRE_OFF_W     = 12;
	localparam int TX_PRE_LEN    = 4;

	// ****************************************************************
	// Controller registers on APB
	// ****************************************************************
	localparam logic [11:0] REG_MAC_CTRL = 12'h000;
	localparam logic [11:0] REG_OFF_CTRL = 12'h004;
	localparam logic [11:0] REG_VLAN     = 12'h008;
	localparam logic [11:0] REG_TX_DATA  = 12'h00c;
	localparam logic [11:0] REG_STATUS   = 12'h010;
	localparam logic [11:0] REG_RX_LEN   = 12'h014;
	localparam int MAC_RX_RUN_BIT  = 2;
	localparam int MAC_TX_RUN_BIT  = 3;
	localparam int MAC_PAD_BIT     = 8;
	localparam int OFF_RX_EN_BIT   = 0;
	localparam int OFF_RX_MODE_BIT = 1;
	localparam int OFF_TX_EN_BIT   = 16;

	// ****************************************************************
	// State codes
	// ****************************************************************
	typedef enum logic [1:0] {
		RX_RUN  = 2'b00,
		RX_FOLD = 2'b01,
		RX_LO   = 2'b10,
		RX_HI   = 2'b11
	} ecso_rx_st_t;

	typedef enum logic [2:0] {
		TX_CMDA = 3'b000,
		TX_CMDB = 3'b001,
		TX_PRE  = 3'b010,
		TX_WORD = 3'b011,
		TX_BYTE = 3'b100,
		TX_FOLD = 3'b101,
		TX_SEND = 3'b110
	} ecso_tx_st_t;

endpackage

// File: verilog/ecso_engine.sv
// Receive and transmit checksum engines on the Ethernet datapath
// Behaviour
// [RL1] Mode 0: sum after byte 14, skip FCS
// [RL2] Mode 1: parse VLAN/SNAP, start at layer 3
// [RL3] VLAN recognised by programmable protocol identifier
// [RL4] Two tags parsed, third acts as type
// [RL5] Forward frame, append 16-bit sum after it
// [RL6] Reported length grows by two bytes
// [RL7] Enable and mode bits; disabled passes through
// [RL8] Host stops and flushes receive before changes
// [RL9] Host never enables offload with pad removal
// [RL10] Sum 16-bit units, odd byte padded zero
// [RL11] Later byte high; carries added back in
// [RL12] Transmit sum needs request, first segment, enable
// [RL13] Host prepends two commands and a preamble
// [RL14] Transmit sum from preamble start to end
// [RL15] Overwrite two bytes at insert offset
// [RL16] Host keeps offsets off header and tail
// [RL17] No request bit: packet passes unaltered
// [RL18] Preamble dropped yet counted in length
// [RL19] Host aligns preamble on word boundary
// [RL20] Host stops transmit before changing enable
// [RL21] Transmit inserts complement of the sum
// [RL22] Receive appends folded sum, not complemented
`timescale 1ns/1ns
module ecso_engine
	import ecso_pkg::*;
#(
	parameter int LEN_W = 11
)
(
	input  wire logic   CLK,
	input  wire logic   RST_N,
	ecso_if.engine      LINK,
	output logic [15:0] RX_SUM,
	output logic        RX_SUM_VALID
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		ecso_rx_st_t            rst;
		logic [13:0]            pos;
		logic [3:0][7:0]        dly;
		logic [13:0]            start;
		logic [13:0]            type_pos;
		logic [1:0]             vlans;
		logic [7:0]             prev;
		logic [7:0]             rlo;
		logic                   rhave;
		logic [15:0]            rsum;
		logic                   rvalid;
		logic [7:0]             rdata;
		logic                   rlast;
		logic                   lvalid;
		logic [13:0]            len;
		logic                   rbusy;
		logic                   sum_valid;
		logic [15:0]            sum_out;
		ecso_tx_st_t            tst;
		logic [31:0]            word;
		logic [1:0]             bsel;
		logic                   fs;
		logic                   act;
		logic [LEN_W-1:0]       tlen;
		logic [LEN_W-1:0]       bidx;
		logic [LEN_W-1:0]       rd;
		logic [PRE_OFF_W-1:0]   sso;
		logic [PRE_OFF_W-1:0]   loc;
		logic [7:0]             tlo;
		logic                   thave;
		logic [15:0]            tsum;
		logic                   in_ready;
		logic                   tvalid;
		logic [7:0]             tdata;
		logic                   tlast;
		logic                   tbusy;
	} ecso_eng_state_t;

	ecso_eng_state_t r;
	ecso_eng_state_t n;
	logic [7:0]      mem [0:(2**LEN_W)-1];
	logic [15:0]     rx_unit;
	logic [15:0]     rx_res;
	logic            rx_add;
	logic [15:0]     tx_unit;
	logic [15:0]     tx_res;
	logic            tx_add;
	logic [15:0]     tval;
	logic [13:0]     rx_start;
	logic            rx_done;
	logic            tx_acc;
	logic [7:0]      tbyte;
	logic            mem_we;

	// Buffer addresses must fit the preamble offsets
	if (LEN_W < 5 || LEN_W > PRE_OFF_W)
		$error("LEN_W must lie between 5 and 12");

	ecso_sum16 u_rx_sum (.acc(r.rsum), .unit(rx_unit), .res(rx_res));
	ecso_sum16 u_tx_sum (.acc(r.tsum), .unit(tx_unit), .res(tx_res));

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		n = r;
		rx_unit = 16'h0000;
		rx_add = 1'b0;
		tx_unit = 16'h0000;
		tx_add = 1'b0;
		tval = {r.prev, LINK.rx_in_data};
		rx_done = 1'b0;
		mem_we = 1'b0;
		tx_acc = LINK.tx_in_valid & r.in_ready;
		tbyte = r.word[{r.bsel, 3'b000} +: 8];
		// Mode 0 start is fixed; mode 1 waits for the parser
		rx_start = LINK.rx_mode ? r.start : RX_HDR_LEN; // [RL1] [RL2]
		n.rvalid = 1'b0;
		n.rlast = 1'b0;
		n.lvalid = 1'b0;
		n.sum_valid = 1'b0;
		unique case (r.rst)
			RX_RUN:
			begin
				if (LINK.rx_in_valid)
				begin
					n.dly = {r.dly[2:0], LINK.rx_in_data};
					n.pos = r.pos + 14'h0001;
					n.prev = LINK.rx_in_data;
					n.rvalid = 1'b1; // [RL5]
					n.rdata = LINK.rx_in_data;
					n.rlast = LINK.rx_in_last & ~LINK.rx_en; // [RL7]
					if (LINK.rx_mode && r.pos == r.type_pos + 14'h0001)
					begin
						if (tval == LINK.vlan_tpid && r.vlans < RX_MAX_VLAN) // [RL3] [RL4]
						begin
							n.type_pos = r.type_pos + RX_TAG_LEN;
							n.vlans = r.vlans + 2'h1;
						end
						else if (tval < RX_TYPE_MIN) // [RL2]
							n.start = r.type_pos + RX_TYPE_LEN + RX_SNAP_LEN;
						else
							n.start = r.type_pos + RX_TYPE_LEN; // [RL4]
					end
					// Bytes leave the delay line only once they cannot be FCS
					if (LINK.rx_en && r.pos >= RX_FCS_LEN && r.pos - RX_FCS_LEN >= rx_start) // [RL1]
					begin
						if (r.rhave)
						begin
							rx_unit = {r.dly[3], r.rlo}; // [RL11]
							rx_add = 1'b1;
							n.rhave = 1'b0;
						end
						else
						begin
							n.rlo = r.dly[3];
							n.rhave = 1'b1;
						end
					end
					if (LINK.rx_in_last)
					begin
						n.len = r.pos + 14'h0001 + (LINK.rx_en ? RX_APPEND_LEN : 14'h0000); // [RL6]
						if (LINK.rx_en)
							n.rst = RX_FOLD;
						else
						begin
							n.lvalid = 1'b1;
							rx_done = 1'b1;
						end
					end
				end
			end
			RX_FOLD:
			begin
				rx_unit = {8'h00, r.rlo}; // [RL10]
				rx_add = r.rhave;
				n.rst = RX_LO;
			end
			RX_LO:
			begin
				n.rvalid = 1'b1;
				n.rdata = r.rsum[7:0]; // [RL22]
				n.rst = RX_HI;
			end
			RX_HI:
			begin
				n.rvalid = 1'b1;
				n.rdata = r.rsum[15:8]; // [RL5]
				n.rlast = 1'b1;
				n.lvalid = 1'b1;
				n.sum_valid = 1'b1;
				n.sum_out = r.rsum;
				rx_done = 1'b1;
			end
		endcase
		if (rx_add)
			n.rsum = rx_res; // [RL11]
		if (rx_done)
		begin
			n.rst = RX_RUN;
			n.pos = 14'h0000;
			n.start = RX_START_NONE;
			n.type_pos = RX_TYPE_POS;
			n.vlans = 2'h0;
			n.rhave = 1'b0;
			n.rsum = 16'h0000;
		end
		n.rbusy = n.rst != RX_RUN || n.pos != 14'h0000;

		// Transmit: store the packet, then replay it with the sum patched in
		if (r.tvalid && LINK.tx_out_ready)
		begin
			n.tvalid = 1'b0;
			n.tlast = 1'b0;
		end
		unique case (r.tst)
			TX_CMDA:
				if (tx_acc)
				begin
					n.fs = LINK.tx_in_data[CMDA_FS_BIT];
					n.tst = TX_CMDB;
				end
			TX_CMDB:
				if (tx_acc)
				begin
					n.act = LINK.tx_in_data[CMDB_REQ_BIT] & r.fs & LINK.tx_en; // [RL12] [RL17]
					// The length counts the preamble, which is not sent
					n.tlen = n.act ? LINK.tx_in_data[LEN_W-1:0] - LEN_W'(TX_PRE_LEN)
						: LINK.tx_in_data[LEN_W-1:0]; // [RL18]
					n.bidx = '0;
					n.tsum = 16'h0000;
					n.thave = 1'b0;
					n.tst = n.act ? TX_PRE : TX_WORD;
				end
			TX_PRE:
				if (tx_acc)
				begin
					n.sso = LINK.tx_in_data[PRE_START_LSB +: PRE_OFF_W]; // [RL14]
					n.loc = LINK.tx_in_data[PRE_LOC_LSB +: PRE_OFF_W]; // [RL15]
					n.tst = TX_WORD;
				end
			TX_WORD:
				if (tx_acc)
				begin
					n.word = LINK.tx_in_data;
					n.bsel = 2'h0;
					n.tst = TX_BYTE;
				end
			TX_BYTE:
			begin
				mem_we = 1'b1;
				if (r.act && PRE_OFF_W'(r.bidx) >= r.sso) // [RL14] [RL21]
				begin
					if (r.thave)
					begin
						tx_unit = {tbyte, r.tlo};
						tx_add = 1'b1;
						n.thave = 1'b0;
					end
					else
					begin
						n.tlo = tbyte;
						n.thave = 1'b1;
					end
				end
				n.bidx = r.bidx + 1'b1;
				// Bytes past the length in the last word are dropped
				if (r.bidx == r.tlen - 1'b1)
					n.tst = TX_FOLD;
				else if (r.bsel == 2'h3)
					n.tst = TX_WORD;
				else
					n.bsel = r.bsel + 2'h1;
			end
			TX_FOLD:
			begin
				tx_unit = {8'h00, r.tlo}; // [RL10]
				tx_add = r.thave;
				n.rd = '0;
				n.tst = TX_SEND;
			end
			TX_SEND:
				if (!r.tvalid || LINK.tx_out_ready)
				begin
					n.tvalid = 1'b1;
					n.tdata = mem[r.rd];
					if (r.act && PRE_OFF_W'(r.rd) == r.loc)
						n.tdata = ~r.tsum[7:0]; // [RL15] [RL21]
					else if (r.act && PRE_OFF_W'(r.rd) == r.loc + 12'h001)
						n.tdata = ~r.tsum[15:8]; // [RL15] [RL21]
					n.tlast = r.rd == r.tlen - 1'b1;
					n.rd = r.rd + 1'b1;
					if (r.rd == r.tlen - 1'b1)
						n.tst = TX_CMDA;
				end
			default:
				n.tst = TX_CMDA;
		endcase
		if (tx_add)
			n.tsum = tx_res;
		n.in_ready = n.tst == TX_CMDA || n.tst == TX_CMDB || n.tst == TX_PRE || n.tst == TX_WORD;
		n.tbusy = n.tst != TX_CMDA || n.tvalid;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Packet store has no reset; it is always written before it is read
	always_ff @(posedge CLK)
	begin
		if (mem_we)
			mem[r.bidx] <= tbyte;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			r <= '0;
			r.start <= RX_START_NONE;
			r.type_pos <= RX_TYPE_POS;
		end
		else
			r <= n;
	end

	assign LINK.rx_out_valid = r.rvalid;
	assign LINK.rx_out_data = r.rdata;
	assign LINK.rx_out_last = r.rlast;
	assign LINK.rx_len_valid = r.lvalid;
	assign LINK.rx_len = r.len;
	assign LINK.rx_busy = r.rbusy;
	assign LINK.tx_in_ready = r.in_ready;
	assign LINK.tx_out_valid = r.tvalid;
	assign LINK.tx_out_data = r.tdata;
	assign LINK.tx_out_last = r.tlast;
	assign LINK.tx_busy = r.tbusy;
	assign RX_SUM = r.sum_out;
	assign RX_SUM_VALID = r.sum_valid;
endmodule

// File: verilog/ecso_mac.sv
// MAC side controller: APB registers, receive gating and transmit word feed
`timescale 1ns/1ns
module ecso_mac
	import ecso_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	ecso_if.mac              LINK,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        MAC_RX_VALID,
	input  wire logic [7:0]  MAC_RX_DATA,
	input  wire logic        MAC_RX_LAST,
	output logic             RX_FIFO_VALID,
	output logic      [7:0]  RX_FIFO_DATA,
	output logic             RX_FIFO_LAST,
	output logic             RX_STATUS_VALID,
	output logic      [13:0] RX_STATUS_LEN,
	output logic             MAC_TX_VALID,
	output logic      [7:0]  MAC_TX_DATA,
	output logic             MAC_TX_LAST,
	input  wire logic        MAC_TX_READY
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic        rx_run;
		logic        tx_run;
		logic        pad;
		logic        rx_en;
		logic        rx_mode;
		logic        tx_en;
		logic [15:0] vlan;
		logic        tx_pend;
		logic [31:0] tx_word;
		logic        rin_valid;
		logic [7:0]  rin_data;
		logic        rin_last;
		logic [13:0] last_len;
		logic [15:0] frames;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} ecso_mac_state_t;

	ecso_mac_state_t r;
	ecso_mac_state_t n;
	logic            rx_chg;
	logic            tx_chg;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		n = r;
		rx_chg = PWDATA[OFF_RX_EN_BIT] != r.rx_en || PWDATA[OFF_RX_MODE_BIT] != r.rx_mode;
		tx_chg = PWDATA[OFF_TX_EN_BIT] != r.tx_en;
		// Receive bytes reach the engine only while reception runs
		n.rin_valid = MAC_RX_VALID & r.rx_run;
		n.rin_data = MAC_RX_DATA;
		n.rin_last = MAC_RX_LAST;
		if (LINK.rx_len_valid)
		begin
			n.last_len = LINK.rx_len;
			n.frames = r.frames + 16'h0001;
		end
		if (r.tx_pend && LINK.tx_in_ready)
			n.tx_pend = 1'b0;
		// Answer one cycle into the access phase; a full word slot stalls
		if (PSEL && PENABLE && !r.pready && !(PWRITE && PADDR == REG_TX_DATA && r.tx_pend))
		begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			n.pslverr = 1'b0;
			case (PADDR)
				REG_MAC_CTRL:
				begin
					n.prdata[MAC_RX_RUN_BIT] = r.rx_run;
					n.prdata[MAC_TX_RUN_BIT] = r.tx_run;
					n.prdata[MAC_PAD_BIT] = r.pad;
					n.pslverr = PWRITE && PWDATA[MAC_PAD_BIT] && r.rx_en; // [RL9]
				end
				REG_OFF_CTRL:
				begin
					n.prdata[OFF_RX_EN_BIT] = r.rx_en;
					n.prdata[OFF_RX_MODE_BIT] = r.rx_mode;
					n.prdata[OFF_TX_EN_BIT] = r.tx_en;
					n.pslverr = PWRITE && ((rx_chg && (r.rx_run || LINK.rx_busy)) // [RL8]
						|| (tx_chg && (r.tx_run || r.tx_pend || LINK.tx_busy)) // [RL20]
						|| (PWDATA[OFF_RX_EN_BIT] && r.pad)); // [RL9]
				end
				REG_VLAN:
					n.prdata[15:0] = r.vlan;
				REG_TX_DATA:
					n.pslverr = !PWRITE || !r.tx_run;
				REG_STATUS:
				begin
					n.prdata = {r.frames, 13'h0000, r.tx_pend, LINK.tx_busy, LINK.rx_busy};
					n.pslverr = PWRITE;
				end
				REG_RX_LEN:
				begin
					n.prdata[13:0] = r.last_len;
					n.pslverr = PWRITE;
				end
				default:
					n.pslverr = 1'b1;
			endcase
		end
		// Writes take effect at the edge that completes the access
		if (PSEL && PENABLE && r.pready)
		begin
			n.pready = 1'b0;
			n.pslverr = 1'b0;
			if (PWRITE && !r.pslverr)
			begin
				case (PADDR)
					REG_MAC_CTRL:
					begin
						n.rx_run = PWDATA[MAC_RX_RUN_BIT];
						n.tx_run = PWDATA[MAC_TX_RUN_BIT];
						n.pad = PWDATA[MAC_PAD_BIT];
					end
					REG_OFF_CTRL:
					begin
						n.rx_en = PWDATA[OFF_RX_EN_BIT];
						n.rx_mode = PWDATA[OFF_RX_MODE_BIT];
						n.tx_en = PWDATA[OFF_TX_EN_BIT];
					end
					REG_VLAN:
						n.vlan = PWDATA[15:0];
					REG_TX_DATA:
					begin
						n.tx_pend = 1'b1; // [RL13] [RL18] [RL19]
						n.tx_word = PWDATA;
					end
					default:
						n.pready = 1'b0;
				endcase
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			r <= '0;
			r.vlan <= VLAN_TPID_RST;
		end
		else
			r <= n;
	end

	// Offsets are the host's to keep clear of header and tail
	assign LINK.rx_en = r.rx_en;
	assign LINK.rx_mode = r.rx_mode;
	assign LINK.tx_en = r.tx_en;
	assign LINK.vlan_tpid = r.vlan; // [RL3]
	assign LINK.rx_in_valid = r.rin_valid;
	assign LINK.rx_in_data = r.rin_data;
	assign LINK.rx_in_last = r.rin_last;
	assign LINK.tx_in_valid = r.tx_pend; // [RL16]
	assign LINK.tx_in_data = r.tx_word;
	assign LINK.tx_out_ready = MAC_TX_READY;
	assign PRDATA = r.prdata;
	assign PREADY = r.pready;
	assign PSLVERR = r.pslverr;
	assign RX_FIFO_VALID = LINK.rx_out_valid;
	assign RX_FIFO_DATA = LINK.rx_out_data;
	assign RX_FIFO_LAST = LINK.rx_out_last;
	assign RX_STATUS_VALID = LINK.rx_len_valid;
	assign RX_STATUS_LEN = LINK.rx_len;
	assign MAC_TX_VALID = LINK.tx_out_valid;
	assign MAC_TX_DATA = LINK.tx_out_data;
	assign MAC_TX_LAST = LINK.tx_out_last;
endmodule

// File: verilog/ecso_mac_fix.sv
// Spare file of the controller end; it holds no logic

// File: verilog/ecso_sum16.sv
// Ones-complement 16-bit adder with end-around carry
`timescale 1ns/1ns
module ecso_sum16
(
	input  wire logic [15:0] acc,
	input  wire logic [15:0] unit,
	output logic      [15:0] res
);
	logic [16:0] raw;

	// Carry folded back in; the second add cannot carry again
	assign raw = {1'b0, acc} + {1'b0, unit};
	assign res = raw[15:0] + {15'h0000, raw[16]};
endmodule
